// File: src/dbgsc_defines.svh
`ifndef DBGSC_DEFINES_SVH
`define DBGSC_DEFINES_SVH

// ----------------------------------------
// status/control field positions
// ----------------------------------------
`define DBGSC_BIT_PERMIT 7
`define DBGSC_BIT_ACTIVE 6
`define DBGSC_BIT_BRKEN 5
`define DBGSC_BIT_FTS 4
`define DBGSC_BIT_CLKSEL 3
`define DBGSC_BIT_WS 2
`define DBGSC_BIT_WSF 1
`define DBGSC_BIT_DVF 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define DBGSC_CTRL_RESET 4'h0
`define DBGSC_BKPT_RESET 16'h0000

// ----------------------------------------
// serial command codes
// ----------------------------------------
`define DBGSC_CMD_NONE 3'h0
`define DBGSC_CMD_RD_STATUS 3'h1
`define DBGSC_CMD_WR_CONTROL 3'h2
`define DBGSC_CMD_RD_BKPT 3'h3
`define DBGSC_CMD_WR_BKPT 3'h4
`define DBGSC_CMD_HALT 3'h5
`define DBGSC_CMD_GO 3'h6

`endif

// File: src/dbgsc_pkg.sv
package dbgsc_pkg;

   typedef enum logic [1:0]
   {
      DBGSC_RUN = 2'b00,
      DBGSC_HALT = 2'b01
   } dbgsc_state_t;

   // serial command from the link decoder
   typedef struct packed
   {
      logic valid;
      logic [2:0] code;
      logic [15:0] data;
   } dbgsc_cmd_t;

   // cpu observation signals
   typedef struct packed
   {
      logic [15:0] addr;
      logic addr_valid;
      logic boundary;
      logic tag_at_end;
      logic wait_stop;
      logic mem_fail_ws;
      logic halt_instr;
   } dbgsc_cpu_t;

endpackage : dbgsc_pkg

// File: src/dbgsc_break_match.sv
`timescale 1ns/100ps

`include "dbgsc_defines.svh"

module dbgsc_break_match
   import dbgsc_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // configuration
   input wire logic enable,
   input wire logic [ADDR_W-1:0] match_addr,
   // cpu address
   input wire logic [ADDR_W-1:0] cpu_addr,
   input wire logic cpu_addr_valid,
   // result
   output logic hit
);

   logic hit_reg;
   logic hit_next;

   always_comb
   begin
      hit_next = 1'b0;
      if (enable && cpu_addr_valid && (cpu_addr == match_addr))
      begin
         hit_next = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         hit_reg <= 1'b0;
      end
      else
      begin
         hit_reg <= hit_next;
      end
   end

   assign hit = hit_reg;

endmodule : dbgsc_break_match

// File: src/dbgsc_core.sv
`timescale 1ns/100ps

`include "dbgsc_defines.svh"

module dbgsc_core
   import dbgsc_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // serial command port
   input wire dbgsc_cmd_t cmd,
   output logic [15:0] rd_data,
   output logic rd_valid,
   // cpu side
   input wire dbgsc_cpu_t cpu,
   output logic halt_req,
   output logic tag_req,
   output logic cpu_resume_halt,
   output logic halted,
   // link clock choice
   output logic comm_clock_select
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   dbgsc_state_t state_reg, state_next;
   logic halt_permit_reg, halt_permit_next;
   logic break_enable_reg, break_enable_next;
   logic force_tag_reg, force_tag_next;
   logic clksel_reg, clksel_next;
   logic ws_halt_reg, ws_halt_next;
   logic wsf_reg, wsf_next;
   logic [ADDR_W-1:0] bkpt_reg, bkpt_next;
   logic [15:0] rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic halt_req_reg, halt_req_next;
   logic tag_req_reg, tag_req_next;
   logic force_pend_reg, force_pend_next;
   logic hit;
   logic [7:0] status_byte;
   logic halted_reg, halted_next;
   logic resume_reg, resume_next;
   logic cmd_wr_ctrl, cmd_halt, cpu_resume_halt_w;

   dbgsc_break_match #(
      .ADDR_W(ADDR_W)
   ) u_match (
      .clock(clock),
      .rst(rst),
      .enable(break_enable_reg),
      .match_addr(bkpt_reg),
      .cpu_addr(cpu.addr),
      .cpu_addr_valid(cpu.addr_valid),
      .hit(hit)
   );

   assign cmd_wr_ctrl = cmd.valid && (cmd.code == `DBGSC_CMD_WR_CONTROL);
   assign cmd_halt = cmd.valid && (cmd.code == `DBGSC_CMD_HALT);
   assign cpu_resume_halt_w = cmd.valid && (cmd.code == `DBGSC_CMD_GO);

   // ----------------------------------------
   // status byte assembly
   // ----------------------------------------
   always_comb
   begin
      status_byte = 8'h00;
      status_byte[`DBGSC_BIT_PERMIT] = halt_permit_reg;
      status_byte[`DBGSC_BIT_ACTIVE] = (state_reg == DBGSC_HALT);
      status_byte[`DBGSC_BIT_BRKEN] = break_enable_reg;
      status_byte[`DBGSC_BIT_FTS] = force_tag_reg;
      status_byte[`DBGSC_BIT_CLKSEL] = clksel_reg;
      status_byte[`DBGSC_BIT_WS] = cpu.wait_stop || ws_halt_reg;
      status_byte[`DBGSC_BIT_WSF] = wsf_reg;
      status_byte[`DBGSC_BIT_DVF] = 1'b0;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      state_next = state_reg;
      halt_permit_next = halt_permit_reg;
      break_enable_next = break_enable_reg;
      force_tag_next = force_tag_reg;
      clksel_next = clksel_reg;
      ws_halt_next = ws_halt_reg;
      wsf_next = wsf_reg;
      bkpt_next = bkpt_reg;
      rd_data_next = rd_data_reg;
      rd_valid_next = 1'b0;
      halt_req_next = 1'b0;
      tag_req_next = 1'b0;
      force_pend_next = force_pend_reg;
      resume_next = 1'b0;

      // serial commands; only this port writes the control bits and the breakpoint register
      if (cmd.valid)
      begin
         case (cmd.code)
            `DBGSC_CMD_RD_STATUS:
            begin
               rd_data_next = {8'h00, status_byte};
               rd_valid_next = 1'b1;
            end
            `DBGSC_CMD_WR_CONTROL:
            begin
               // status bits untouched by this write, except WSF which it clears
               if (state_reg != DBGSC_HALT)
               begin
                  // cleared only by reset once set
                  halt_permit_next = halt_permit_reg | cmd.data[`DBGSC_BIT_PERMIT];
               end
               break_enable_next = cmd.data[`DBGSC_BIT_BRKEN];
               force_tag_next = cmd.data[`DBGSC_BIT_FTS];
               clksel_next = cmd.data[`DBGSC_BIT_CLKSEL];
               wsf_next = 1'b0;
            end
            `DBGSC_CMD_RD_BKPT:
            begin
               rd_data_next = 16'(bkpt_reg);
               rd_valid_next = 1'b1;
            end
            `DBGSC_CMD_WR_BKPT:
            begin
               bkpt_next = cmd.data[ADDR_W-1:0];
            end
            default:
            begin
            end
         endcase
      end

      // memory command collided with wait/stop; set wins over clear
      if (cpu.mem_fail_ws)
      begin
         wsf_next = 1'b1;
      end

      // breakpoint requests; enable rechecked so a match in flight dies with it
      force_pend_next = break_enable_reg && (force_pend_reg || (hit && force_tag_reg));
      tag_req_next = break_enable_reg && hit && !force_tag_reg;

      case (state_reg)
         DBGSC_RUN:
         begin
            if (halt_permit_reg)
            begin
               if (cmd_halt)
               begin
                  state_next = DBGSC_HALT;
                  ws_halt_next = cpu.wait_stop;
                  halt_req_next = 1'b1;
                  force_pend_next = 1'b0;
               end
               else if ((force_pend_reg && cpu.boundary) || cpu.tag_at_end || cpu.halt_instr)
               begin
                  state_next = DBGSC_HALT;
                  halt_req_next = 1'b1;
                  force_pend_next = 1'b0;
               end
            end
            else
            begin
               force_pend_next = 1'b0;
            end
         end
         DBGSC_HALT:
         begin
            force_pend_next = 1'b0;
            if (cpu_resume_halt_w)
            begin
               state_next = DBGSC_RUN;
               ws_halt_next = 1'b0;
               resume_next = 1'b1;
            end
         end
         default:
         begin
            state_next = DBGSC_RUN;
         end
      endcase
      halted_next = (state_next == DBGSC_HALT);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= DBGSC_RUN;
         halt_permit_reg <= 1'b0;
         break_enable_reg <= 1'b0;
         force_tag_reg <= 1'b0;
         clksel_reg <= 1'b0;
         ws_halt_reg <= 1'b0;
         wsf_reg <= 1'b0;
         bkpt_reg <= ADDR_W'(`DBGSC_BKPT_RESET);
         rd_data_reg <= 16'h0000;
         rd_valid_reg <= 1'b0;
         halt_req_reg <= 1'b0;
         tag_req_reg <= 1'b0;
         force_pend_reg <= 1'b0;
         halted_reg <= 1'b0;
         resume_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         halt_permit_reg <= halt_permit_next;
         break_enable_reg <= break_enable_next;
         force_tag_reg <= force_tag_next;
         clksel_reg <= clksel_next;
         ws_halt_reg <= ws_halt_next;
         wsf_reg <= wsf_next;
         bkpt_reg <= bkpt_next;
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
         halt_req_reg <= halt_req_next;
         tag_req_reg <= tag_req_next;
         force_pend_reg <= force_pend_next;
         halted_reg <= halted_next;
         resume_reg <= resume_next;
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign halt_req = halt_req_reg;
   assign tag_req = tag_req_reg;
   assign cpu_resume_halt = resume_reg;
   assign halted = halted_reg;
   assign comm_clock_select = clksel_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   permit_sticky_a: assert property (@(posedge clock) disable iff (rst)
      $past(halt_permit_reg) |-> halt_permit_reg)
      else $error("halt permit dropped without reset");

   no_halt_unpermitted_a: assert property (@(posedge clock) disable iff (rst)
      (state_reg == DBGSC_RUN && !halt_permit_reg) |=> state_reg == DBGSC_RUN)
      else $error("halt entered without permit");

   halt_cmd_enters_a: assert property (@(posedge clock) disable iff (rst)
      (state_reg == DBGSC_RUN && halt_permit_reg && cmd_halt) |=> (halted && halt_req))
      else $error("halt command did not enter halt");

   dvf_zero_a: assert property (@(posedge clock) disable iff (rst)
      rd_valid && $past(cmd.code) == `DBGSC_CMD_RD_STATUS |-> rd_data[`DBGSC_BIT_DVF] == 1'b0)
      else $error("data valid fail read nonzero");

   wsf_set_a: assert property (@(posedge clock) disable iff (rst)
      cpu.mem_fail_ws |=> wsf_reg)
      else $error("wait stop fail not set");

   permit_locked_a: assert property (@(posedge clock) disable iff (rst)
      (halted && cmd_wr_ctrl) |=> $stable(halt_permit_reg))
      else $error("permit changed while halted");

   break_off_a: assert property (@(posedge clock) disable iff (rst)
      !break_enable_reg |=> !tag_req)
      else $error("tag request with breakpoint disabled");

   clksel_write_a: assert property (@(posedge clock) disable iff (rst)
      cmd_wr_ctrl |=> clksel_reg == $past(cmd.data[`DBGSC_BIT_CLKSEL]))
      else $error("clock select not written");

endmodule : dbgsc_core

// File: dv/dbgsc_host.sv
`timescale 1ns/100ps

`include "dbgsc_defines.svh"

// ----------------------------------------
// debug host issuing serial commands
// ----------------------------------------
module dbgsc_host
   import dbgsc_pkg::*;
(
   // clock
   input wire logic clock,
   // command port
   output dbgsc_cmd_t cmd,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);
   initial cmd = '0;

   // one command; read data is registered on the same edge that takes it and is sampled just after that edge
   task automatic xfer(input logic [2:0] code, input logic [15:0] data, output logic [15:0] q);
      @(posedge clock);
      cmd <= {1'b1, code, data};
      @(posedge clock);
      cmd.valid <= 1'b0;
      cmd.data <= ~data;
      #1;
      q = rd_valid ? rd_data : 16'hDEAD;
   endtask : xfer

   // halt, then read the status byte back for the caller before anything else
   task automatic force_halt(output logic [15:0] s);
      logic [15:0] q;
      xfer(`DBGSC_CMD_HALT, 16'h0000, q);
      xfer(`DBGSC_CMD_RD_STATUS, 16'h0000, s);
   endtask : force_halt
endmodule : dbgsc_host

// File: dv/tb_top.sv
`timescale 1ns/100ps

`include "dbgsc_defines.svh"

module tb_top;
   import dbgsc_pkg::*;

   localparam logic [2:0] GO_CMD = 3'h6;
   logic clock;
   logic rst;
   dbgsc_cmd_t cmd;
   dbgsc_cpu_t cpu;
   logic [15:0] rd_data;
   logic rd_valid;
   logic halt_req;
   logic tag_req;
   logic cpu_resume_halt;
   logic halted;
   logic comm_clock_select;
   logic [15:0] q;
   int error_cnt = 0;
   int n_tests = 0;
   int tag_cnt = 0;
   int halt_cnt = 0;
   int resume_cnt = 0;

   dbgsc_core uut (.clock(clock), .rst(rst), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid), .cpu(cpu),
      .halt_req(halt_req), .tag_req(tag_req), .cpu_resume_halt(cpu_resume_halt), .halted(halted),
      .comm_clock_select(comm_clock_select));
   dbgsc_host host (.clock(clock), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid));

   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   always @(posedge clock)
   begin
      if (tag_req === 1'b1)
         tag_cnt <= tag_cnt + 1;
      if (halt_req === 1'b1)
         halt_cnt <= halt_cnt + 1;
      if (cpu_resume_halt === 1'b1)
         resume_cnt <= resume_cnt + 1;
   end

   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   task automatic st(input logic [7:0] e);
      host.xfer(`DBGSC_CMD_RD_STATUS, 16'h0000, q);
      chk(q, {8'h00, e});
   endtask : st

   task automatic ctl(input logic [2:0] code, input logic [15:0] d);
      host.xfer(code, d, q);
   endtask : ctl

   // address match, then an instruction boundary
   task automatic brk(input logic [15:0] a);
      @(posedge clock);
      cpu.addr <= a;
      cpu.addr_valid <= 1'b1;
      @(posedge clock);
      cpu.addr_valid <= 1'b0;
      cpu.addr <= ~a;
      repeat (3) @(posedge clock);
      cpu.boundary <= 1'b1;
      @(posedge clock);
      cpu.boundary <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
   endtask : brk

   initial
   begin
      #100000;
      error_cnt++;
      end_of_test();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      cpu = '0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      st(8'h00);
      ctl(`DBGSC_CMD_RD_BKPT, 16'h0000);
      chk(q, 16'h0000);
      chk(16'(comm_clock_select), 16'h0000);
      ctl(`DBGSC_CMD_HALT, 16'h0000);
      chk(16'(halted), 16'h0000);
      st(8'h00);
      ctl(`DBGSC_CMD_WR_BKPT, 16'hA5C3);
      ctl(`DBGSC_CMD_RD_BKPT, 16'h0000);
      chk(q, 16'hA5C3);
      ctl(`DBGSC_CMD_WR_CONTROL, 16'h00FF);
      st(8'hB8);
      chk(16'(comm_clock_select), 16'h0001);
      ctl(`DBGSC_CMD_WR_CONTROL, 16'h0000);
      st(8'h80);
      chk(16'(comm_clock_select), 16'h0000);
      host.force_halt(q);
      chk(q, 16'h00C0);
      ctl(`DBGSC_CMD_WR_CONTROL, 16'h0000);
      st(8'hC0);
      ctl(GO_CMD, 16'h0000);
      st(8'h80);
      @(posedge clock);
      cpu.wait_stop <= 1'b1;
      st(8'h84);
      host.force_halt(q);
      chk(q, 16'h00C4);
      @(posedge clock);
      cpu.wait_stop <= 1'b0;
      st(8'hC4);
      ctl(GO_CMD, 16'h0000);
      st(8'h80);
      @(posedge clock);
      cpu.mem_fail_ws <= 1'b1;
      @(posedge clock);
      cpu.mem_fail_ws <= 1'b0;
      st(8'h82);
      host.force_halt(q);
      ctl(`DBGSC_CMD_RD_BKPT, 16'h0000);
      chk(q, 16'hA5C3);
      ctl(`DBGSC_CMD_WR_CONTROL, 16'h0080);
      st(8'hC0);
      ctl(`DBGSC_CMD_WR_BKPT, 16'h1234);
      ctl(`DBGSC_CMD_WR_CONTROL, 16'h00B0);
      ctl(GO_CMD, 16'h0000);
      brk(16'h1235);
      chk(16'(halted), 16'h0000);
      brk(16'h1234);
      chk(16'(halted), 16'h0001);
      ctl(`DBGSC_CMD_WR_CONTROL, 16'h00A0);
      ctl(GO_CMD, 16'h0000);
      brk(16'h1234);
      chk(16'(halted), 16'h0000);
      chk(16'(tag_cnt), 16'h0001);
      @(posedge clock);
      cpu.tag_at_end <= 1'b1;
      @(posedge clock);
      cpu.tag_at_end <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk(16'(halted), 16'h0001);
      ctl(`DBGSC_CMD_WR_CONTROL, 16'h0090);
      ctl(GO_CMD, 16'h0000);
      brk(16'h1234);
      chk(16'(halted), 16'h0000);
      chk(16'(tag_cnt), 16'h0001);
      @(posedge clock);
      cpu.halt_instr <= 1'b1;
      @(posedge clock);
      cpu.halt_instr <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk(16'(halted), 16'h0001);
      chk(16'(halt_cnt), 16'h0006);
      chk(16'(resume_cnt), 16'h0005);
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      st(8'h00);
      chk(16'(halted), 16'h0000);
      end_of_test();
   end
endmodule : tb_top
